// *** csrg_regs.svh ***
// Offsets, keys, reset values and counts for the stack and register guard block.
`ifndef CSRG_REGS_SVH
`define CSRG_REGS_SVH

// ----------------------------------------------------------------------
// I/O register offsets
// ----------------------------------------------------------------------
`define CSRG_CCP_OFF      16'h0004
`define CSRG_TEMP_OFF     16'h0005
`define CSRG_SPL_OFF      16'h000D
`define CSRG_SPH_OFF      16'h000E

// ----------------------------------------------------------------------
// Change guard keys and status bits
// ----------------------------------------------------------------------
`define CSRG_KEY_IO       8'hD8
`define CSRG_KEY_SPM      8'h9D
`define CSRG_CCP_IO_BIT   0
`define CSRG_CCP_SPM_BIT  1

// ----------------------------------------------------------------------
// Instruction windows
// ----------------------------------------------------------------------
`define CSRG_CCP_WINDOW   3'h4
`define CSRG_SPL_HOLD     3'h4

// ----------------------------------------------------------------------
// Stack and register file
// ----------------------------------------------------------------------
`define CSRG_SRAM_TOP     16'h3FFF
`define CSRG_STACK_FLOOR  16'h2000
`define CSRG_NUM_GPR      32
`define CSRG_X_LOW        5'h1A
`define CSRG_Y_LOW        5'h1C
`define CSRG_Z_LOW        5'h1E
`define CSRG_RESET_BYTE   8'h00

`endif

// *** csrg_pkg.sv ***
// Types and helper functions shared by the stack and register guard block.
package csrg_pkg;
`include "csrg_regs.svh"

   typedef enum logic [2:0] {STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET} csrg_stk_op_t;
   typedef enum logic [1:0] {PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PREDEC} csrg_ptr_mode_t;
   typedef enum logic [1:0] {USE_DATA, USE_PM_LOAD, USE_INDIRECT_CALL_OP, USE_INDIRECT_JUMP_OP} csrg_ptr_use_t;
   typedef enum logic [1:0] {SEL_FIRST, SEL_SECOND, SEL_THIRD} csrg_ptr_sel_t;
   typedef enum logic [2:0] {ST_IDLE, ST_POP_RD, ST_POP_CAP, ST_CALL_HI,
                             ST_RET_HI, ST_RET_LO, ST_RET_END} csrg_stk_state_t;

   typedef struct packed {
      csrg_stk_op_t op;
      logic [7:0]   byte_data;
      logic [15:0]  ret_word;
   } csrg_stk_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } csrg_stk_mem_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } csrg_word_out_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } csrg_io_req_t;

   typedef struct packed {
      logic dmem_wr;
      logic nvm_access;
      logic sleep;
      logic insn_done;
   } csrg_cpu_evt_t;

   typedef struct packed {
      logic [4:0] addr_a;
      logic [4:0] addr_b;
      logic [4:0] addr_w;
   } csrg_gpr_rd_t;

   typedef struct packed {
      logic        we8;
      logic [4:0]  addr8;
      logic [7:0]  data8;
      logic        we16;
      logic [4:0]  addr16;
      logic [15:0] data16;
   } csrg_gpr_wr_t;

   typedef struct packed {
      logic           valid;
      csrg_ptr_sel_t  sel;
      csrg_ptr_mode_t mode;
      csrg_ptr_use_t  use_kind;
      logic [5:0]     disp;
   } csrg_ptr_req_t;

   typedef struct packed {
      logic [`CSRG_NUM_GPR-1:0][7:0] regs;
   } csrg_gpr_state_t;

   typedef struct packed {
      csrg_stk_state_t fsm;
      logic [15:0]     sp;
      logic [7:0]      temp;
      logic [7:0]      ret_hi;
      logic [2:0]      ccp_cnt;
      logic            ccp_io;
      logic            ccp_spm;
      logic [2:0]      spl_cnt;
      logic [7:0]      io_rdata;
      csrg_stk_mem_t   stk_mem;
      csrg_word_out_t  pop_out;
      logic            busy;
      logic [7:0]      rd_a;
      logic [7:0]      rd_b;
      logic [15:0]     rd_w;
      csrg_word_out_t  ptr_addr;
      logic            irq_block;
   } csrg_core_state_t;

   // Register index of the low byte of a pointer pair.
   function automatic logic [4:0] csrg_ptr_index(input csrg_ptr_sel_t sel);
      case (sel)
         SEL_FIRST:  return `CSRG_X_LOW;
         SEL_SECOND: return `CSRG_Y_LOW;
         default:    return `CSRG_Z_LOW;
      endcase
   endfunction

   // Sixteen-bit step up or down by one, wrapping.
   function automatic logic [15:0] csrg_step(input logic [15:0] v, input logic up);
      return up ? v + 16'h0001 : v - 16'h0001;
   endfunction

endpackage

// *** csrg_gpr_file.sv ***
// Thirty-two byte working register file with pair and pointer ports.
`timescale 1ns/1ps
`include "csrg_regs.svh"
module csrg_gpr_file
   import csrg_pkg::*;
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   // Operand reads and result writes
   input  wire csrg_gpr_rd_t  rd,
   input  wire csrg_gpr_wr_t  wr,
   output logic [7:0]         rd_a,
   output logic [7:0]         rd_b,
   output logic [15:0]        rd_w,
   // Pointer pair port
   input  wire csrg_ptr_sel_t ptr_sel,
   input  wire logic          ptr_we,
   input  wire logic [15:0]   ptr_wdata,
   output logic [15:0]        ptr_val
);

   csrg_gpr_state_t q;
   csrg_gpr_state_t next_q;
   logic [4:0]      ptr_lo;

   // ----------------------------------------------------------------------
   // Reads
   // ----------------------------------------------------------------------
   // single cycle access
   assign ptr_lo  = csrg_ptr_index(ptr_sel);
   assign rd_a    = q.regs[rd.addr_a];
   assign rd_b    = q.regs[rd.addr_b];
   assign rd_w    = {q.regs[{rd.addr_w[4:1], 1'b1}], q.regs[{rd.addr_w[4:1], 1'b0}]};
   assign ptr_val = {q.regs[ptr_lo | 5'h01], q.regs[ptr_lo]};

   // ----------------------------------------------------------------------
   // Writes
   // ----------------------------------------------------------------------
   always_comb begin
      next_q = q;
      if (wr.we8) begin
         next_q.regs[wr.addr8] = wr.data8;
      end
      if (wr.we16) begin
         next_q.regs[{wr.addr16[4:1], 1'b0}] = wr.data16[7:0];
         next_q.regs[{wr.addr16[4:1], 1'b1}] = wr.data16[15:8];
      end
      if (ptr_we) begin
         next_q.regs[ptr_lo]         = ptr_wdata[7:0];
         next_q.regs[ptr_lo | 5'h01] = ptr_wdata[15:8];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

endmodule

// *** csrg_core.sv ***
// Stack pointer, register file, 16-bit access and change guard for the CPU.
//
// Summary of operation
// - Push stores then decrements; pop increments first.
// - Reset loads stack pointer with SRAM top.
// - Call pushes word, low byte higher, minus two.
// - Returns pop two bytes, stack plus two.
// - Low byte write blocks interrupts up to four instructions or until the next I/O write.
// - Stack pointer is two I/O bytes.
// - Thirty-two byte registers, single cycle access.
// - Byte and word operand/result port combinations.
// - Data memory accesses never reach registers.
// - Three pointer pairs, low byte lower index.
// - Program load and indirect branches use third.
// - Displacement, post-increment and pre-decrement pointer modes.
// - Low write held; high write merges it.
// - Low read captures high byte for later.
// - Temporary byte is directly readable and writable.
// - Protected changes need a prior key.
// - Protected write accepted within four instructions.
// - Memory writes, NVM accesses, sleep close window.
// - Keys select I/O or self-programming unlock.
// - Interrupts held pending while window open.
// - Guard register reads mode bits, rest zero.
`timescale 1ns/1ps
`include "csrg_regs.svh"
module csrg_core
   import csrg_pkg::*;
#(
   parameter logic [15:0] SRAM_TOP = `CSRG_SRAM_TOP
)
(
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   // I/O register access from the pipeline
   input  wire csrg_io_req_t   io_req,
   output logic [7:0]          io_rdata,
   // Pipeline events
   input  wire csrg_cpu_evt_t  cpu_evt,
   // Stack operations and stack memory
   input  wire csrg_stk_req_t  stk_req,
   input  wire logic [7:0]     stk_rdata,
   output logic                stk_busy,
   output csrg_stk_mem_t       stk_mem,
   output csrg_word_out_t      pop_out,
   // Working registers
   input  wire csrg_gpr_rd_t   gpr_rd,
   input  wire csrg_gpr_wr_t   gpr_wr,
   output logic [7:0]          gpr_rd_a,
   output logic [7:0]          gpr_rd_b,
   output logic [15:0]         gpr_rd_w,
   // Pointer addressing
   input  wire csrg_ptr_req_t  ptr_req,
   output csrg_word_out_t      ptr_addr,
   // Protection and interrupt blocking
   output logic                io_unlock,
   output logic                spm_unlock,
   output logic                irq_block
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (SRAM_TOP <= `CSRG_STACK_FLOOR) begin : g_bad_top
      $error("SRAM_TOP must lie above the stack floor.");
   end

   csrg_core_state_t q;
   csrg_core_state_t next_q;
   csrg_ptr_sel_t    ptr_sel_eff;
   logic [15:0]      ptr_val;
   logic [15:0]      ptr_new;
   logic             ptr_we;
   logic [7:0]       file_a;
   logic [7:0]       file_b;
   logic [15:0]      file_w;
   logic             close_evt;

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   csrg_gpr_file i_csrg_gpr_file (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .rd        (gpr_rd),
      .wr        (gpr_wr),
      .rd_a      (file_a),
      .rd_b      (file_b),
      .rd_w      (file_w),
      .ptr_sel   (ptr_sel_eff),
      .ptr_we    (ptr_we),
      .ptr_wdata (ptr_new),
      .ptr_val   (ptr_val)
   );

   // ----------------------------------------------------------------------
   // Pointer addressing
   // ----------------------------------------------------------------------
   // third pair forced
   assign ptr_sel_eff = (ptr_req.use_kind == USE_DATA) ? ptr_req.sel : SEL_THIRD;
   assign ptr_we      = ptr_req.valid &&
                        (ptr_req.mode == PTR_POSTINC || ptr_req.mode == PTR_PREDEC);
   assign ptr_new     = csrg_step(ptr_val, ptr_req.mode == PTR_POSTINC);

   assign close_evt = io_req.wr || cpu_evt.dmem_wr || cpu_evt.nvm_access || cpu_evt.sleep;

   always_comb begin
      next_q               = q;
      next_q.stk_mem.we    = 1'b0;
      next_q.stk_mem.re    = 1'b0;
      next_q.pop_out.valid = 1'b0;

      // --------------------------------------------------------------------
      // Register file read data and effective address
      // --------------------------------------------------------------------
      next_q.rd_a = file_a;
      next_q.rd_b = file_b;
      next_q.rd_w = file_w;
      next_q.ptr_addr.valid = ptr_req.valid;
      case (ptr_req.mode)
         PTR_DISP:    next_q.ptr_addr.data = ptr_val + {10'h000, ptr_req.disp};
         PTR_PREDEC:  next_q.ptr_addr.data = ptr_new;
         default:     next_q.ptr_addr.data = ptr_val;
      endcase

      // --------------------------------------------------------------------
      // Stack sequencer
      // --------------------------------------------------------------------
      case (q.fsm)
         ST_IDLE: begin
            case (stk_req.op)
               STK_PUSH: begin
                  next_q.stk_mem.addr  = q.sp;
                  next_q.stk_mem.wdata = stk_req.byte_data;
                  next_q.stk_mem.we    = 1'b1;
                  next_q.sp            = csrg_step(q.sp, 1'b0);
               end
               STK_POP: begin
                  next_q.sp           = csrg_step(q.sp, 1'b1);
                  next_q.stk_mem.addr = csrg_step(q.sp, 1'b1);
                  next_q.stk_mem.re   = 1'b1;
                  next_q.fsm          = ST_POP_RD;
               end
               STK_CALL: begin
                  next_q.stk_mem.addr  = q.sp;
                  next_q.stk_mem.wdata = stk_req.ret_word[7:0];
                  next_q.stk_mem.we    = 1'b1;
                  next_q.ret_hi        = stk_req.ret_word[15:8];
                  next_q.sp            = csrg_step(q.sp, 1'b0);
                  next_q.fsm           = ST_CALL_HI;
               end
               STK_RET: begin
                  next_q.sp           = csrg_step(q.sp, 1'b1);
                  next_q.stk_mem.addr = csrg_step(q.sp, 1'b1);
                  next_q.stk_mem.re   = 1'b1;
                  next_q.fsm          = ST_RET_HI;
               end
               default: begin
                  next_q.fsm = ST_IDLE;
               end
            endcase
         end
         ST_CALL_HI: begin
            next_q.stk_mem.addr  = q.sp;
            next_q.stk_mem.wdata = q.ret_hi;
            next_q.stk_mem.we    = 1'b1;
            next_q.sp            = csrg_step(q.sp, 1'b0);
            next_q.fsm           = ST_IDLE;
         end
         ST_POP_RD: begin
            next_q.fsm = ST_POP_CAP;
         end
         ST_POP_CAP: begin
            next_q.pop_out.valid = 1'b1;
            next_q.pop_out.data  = {8'h00, stk_rdata};
            next_q.fsm           = ST_IDLE;
         end
         ST_RET_HI: begin
            next_q.sp           = csrg_step(q.sp, 1'b1);
            next_q.stk_mem.addr = csrg_step(q.sp, 1'b1);
            next_q.stk_mem.re   = 1'b1;
            next_q.fsm          = ST_RET_LO;
         end
         ST_RET_LO: begin
            next_q.ret_hi = stk_rdata;
            next_q.fsm    = ST_RET_END;
         end
         ST_RET_END: begin
            next_q.pop_out.valid = 1'b1;
            next_q.pop_out.data  = {q.ret_hi, stk_rdata};
            next_q.fsm           = ST_IDLE;
         end
         default: begin
            next_q.fsm = ST_IDLE;
         end
      endcase

      // --------------------------------------------------------------------
      // Instruction windows
      // --------------------------------------------------------------------
      // count four instructions
      if (q.ccp_cnt != 3'h0 && cpu_evt.insn_done) begin
         next_q.ccp_cnt = q.ccp_cnt - 3'h1;
      end
      if (close_evt) begin
         next_q.ccp_cnt = 3'h0;
      end
      if (q.spl_cnt != 3'h0 && cpu_evt.insn_done) begin
         next_q.spl_cnt = q.spl_cnt - 3'h1;
      end
      if (io_req.wr) begin
         next_q.spl_cnt = 3'h0;
      end

      // --------------------------------------------------------------------
      // I/O register reads
      // --------------------------------------------------------------------
      if (io_req.rd) begin
         case (io_req.addr)
            `CSRG_CCP_OFF: begin
               next_q.io_rdata = `CSRG_RESET_BYTE;
               next_q.io_rdata[`CSRG_CCP_IO_BIT]  = q.ccp_io;
               next_q.io_rdata[`CSRG_CCP_SPM_BIT] = q.ccp_spm;
            end
            `CSRG_TEMP_OFF: next_q.io_rdata = q.temp;
            `CSRG_SPL_OFF: begin
               next_q.io_rdata = q.sp[7:0];
               next_q.temp     = q.sp[15:8];
            end
            `CSRG_SPH_OFF: next_q.io_rdata = q.temp;
            default:       next_q.io_rdata = `CSRG_RESET_BYTE;
         endcase
      end

      // --------------------------------------------------------------------
      // I/O register writes
      // --------------------------------------------------------------------
      if (io_req.wr) begin
         case (io_req.addr)
            `CSRG_CCP_OFF: begin
               if (io_req.wdata == `CSRG_KEY_IO) begin
                  next_q.ccp_io  = 1'b1;
                  next_q.ccp_spm = 1'b0;
                  next_q.ccp_cnt = `CSRG_CCP_WINDOW;
               end else if (io_req.wdata == `CSRG_KEY_SPM) begin
                  next_q.ccp_io  = 1'b0;
                  next_q.ccp_spm = 1'b1;
                  next_q.ccp_cnt = `CSRG_CCP_WINDOW;
               end
            end
            `CSRG_TEMP_OFF: next_q.temp = io_req.wdata;
            `CSRG_SPL_OFF: begin
               next_q.temp    = io_req.wdata;
               next_q.spl_cnt = `CSRG_SPL_HOLD;
            end
            `CSRG_SPH_OFF: next_q.sp = {io_req.wdata, q.temp};
            default: begin
               next_q.temp = next_q.temp;
            end
         endcase
      end

      if (next_q.ccp_cnt == 3'h0) begin
         next_q.ccp_io  = 1'b0;
         next_q.ccp_spm = 1'b0;
      end

      next_q.irq_block = (next_q.ccp_cnt != 3'h0) || (next_q.spl_cnt != 3'h0);
      next_q.busy      = (next_q.fsm != ST_IDLE);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q    <= '0;
         q.sp <= SRAM_TOP;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign io_rdata   = q.io_rdata;
   assign stk_busy   = q.busy;
   assign stk_mem    = q.stk_mem;
   assign pop_out    = q.pop_out;
   assign gpr_rd_a   = q.rd_a;
   assign gpr_rd_b   = q.rd_b;
   assign gpr_rd_w   = q.rd_w;
   assign ptr_addr   = q.ptr_addr;
   assign io_unlock  = q.ccp_io;
   assign spm_unlock = q.ccp_spm;
   assign irq_block  = q.irq_block;

endmodule

// *** csrg_core_assertions.sv ***
// Concurrent checks on the ports of the stack and register guard core.
`timescale 1ns/1ps
`include "csrg_regs.svh"
module csrg_core_assertions
   import csrg_pkg::*;
(
   // Clock and reset
   input wire logic           ref_clk,
   input wire logic           rst_n,
   // Requests from the pipeline
   input wire csrg_io_req_t   io_req,
   input wire csrg_cpu_evt_t  cpu_evt,
   input wire csrg_stk_req_t  stk_req,
   input wire csrg_ptr_req_t  ptr_req,
   // Responses of the core
   input wire logic [7:0]     io_rdata,
   input wire logic           stk_busy,
   input wire csrg_stk_mem_t  stk_mem,
   input wire csrg_word_out_t pop_out,
   input wire csrg_word_out_t ptr_addr,
   input wire logic           io_unlock,
   input wire logic           spm_unlock,
   input wire logic           irq_block
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic ccp_wr;
   logic key_io;
   logic key_spm;
   logic closer;
   assign ccp_wr  = io_req.wr && io_req.addr == `CSRG_CCP_OFF;
   assign key_io  = ccp_wr && io_req.wdata == `CSRG_KEY_IO;
   assign key_spm = ccp_wr && io_req.wdata == `CSRG_KEY_SPM;
   assign closer  = io_req.wr || cpu_evt.dmem_wr || cpu_evt.nvm_access || cpu_evt.sleep;

   sequence s_call_lo;
      stk_mem.we && stk_mem.wdata == $past(stk_req.ret_word[7:0]);
   endsequence
   sequence s_call_hi;
      stk_mem.we && stk_mem.addr == $past(stk_mem.addr) - 16'h0001
         && stk_mem.wdata == $past(stk_req.ret_word[15:8], 2);
   endsequence
   sequence s_ret_rd;
      stk_mem.re ##1 stk_mem.re && stk_mem.addr == $past(stk_mem.addr) + 16'h0001;
   endsequence

   property p_push;
      stk_req.op == STK_PUSH && !stk_busy
         |=> stk_mem.we && stk_mem.wdata == $past(stk_req.byte_data);
   endproperty
   property p_pop;
      stk_req.op == STK_POP && !stk_busy
         |=> stk_mem.re ##2 pop_out.valid && pop_out.data[15:8] == 8'h00;
   endproperty
   property p_call;
      stk_req.op == STK_CALL && !stk_busy |=> s_call_lo ##1 s_call_hi;
   endproperty
   property p_ret;
      stk_req.op == STK_RET && !stk_busy |=> s_ret_rd ##2 pop_out.valid;
   endproperty
   property p_spl_block;
      io_req.wr && io_req.addr == `CSRG_SPL_OFF |=> irq_block;
   endproperty
   property p_key_io;
      key_io |=> io_unlock && !spm_unlock;
   endproperty
   property p_key_spm;
      key_spm |=> spm_unlock && !io_unlock;
   endproperty
   property p_close;
      io_unlock && closer && !key_io && !key_spm |=> !io_unlock;
   endproperty
   property p_hold;
      io_unlock || spm_unlock |-> irq_block;
   endproperty
   property p_ccp_rd;
      io_req.rd && io_req.addr == `CSRG_CCP_OFF && !io_req.wr
         |=> io_rdata == {6'h00, $past(spm_unlock), $past(io_unlock)};
   endproperty
   property p_ptr;
      ptr_req.valid |=> ptr_addr.valid;
   endproperty

   a_push: assert property (p_push) else $error("push did not write its byte");
   a_pop: assert property (p_pop) else $error("pop result missing");
   a_call: assert property (p_call) else $error("call pushed wrong bytes");
   a_ret: assert property (p_ret) else $error("return read order wrong");
   a_spl_block: assert property (p_spl_block) else $error("low byte write not blocking");
   a_key_io: assert property (p_key_io) else $error("io key did not unlock");
   a_key_spm: assert property (p_key_spm) else $error("spm key did not unlock");
   a_close: assert property (p_close) else $error("window stayed open");
   a_hold: assert property (p_hold) else $error("interrupts not held in window");
   a_ccp_rd: assert property (p_ccp_rd) else $error("guard read wrong");
   a_ptr: assert property (p_ptr) else $error("pointer address missing");
endmodule

bind csrg_core csrg_core_assertions i_csrg_core_assertions (.*);

// *** csrg_sram_model.sv ***
// Synchronous stack memory on the far side of the core.
`timescale 1ns/1ps
module csrg_sram_model
   import csrg_pkg::*;
(
   // Clock
   input  wire logic          ref_clk,
   // Stack memory port
   input  wire csrg_stk_mem_t stk_mem,
   output logic [7:0]         stk_rdata
);
   logic [7:0] mem [0:65535];

   initial stk_rdata = 8'h00;
   always @(posedge ref_clk) begin
      if (stk_mem.we)
         mem[stk_mem.addr] <= stk_mem.wdata;
      // Data lives one cycle; otherwise the inverse shows so stale use is caught.
      stk_rdata <= stk_mem.re ? mem[stk_mem.addr] : ~stk_rdata;
   end
endmodule

// *** csrg_core_tb.sv ***
// Self-checking bench for the stack and register guard core.
`timescale 1ns/1ps
`include "csrg_regs.svh"
module csrg_core_tb
   import csrg_pkg::*;
;
   typedef struct packed {logic w; logic [4:0] a; logic [15:0] d;} csrg_row_t;
   localparam csrg_cpu_evt_t insn_ev = 4'h1;
   logic           ref_clk, rst_n, stk_busy, io_unlock, spm_unlock, irq_block;
   logic [7:0]     io_rdata, stk_rdata, gpr_rd_a, gpr_rd_b;
   logic [15:0]    gpr_rd_w;
   csrg_io_req_t   io_req;
   csrg_cpu_evt_t  cpu_evt;
   csrg_stk_req_t  stk_req;
   csrg_stk_mem_t  stk_mem;
   csrg_word_out_t pop_out, ptr_addr;
   csrg_gpr_rd_t   gpr_rd;
   csrg_gpr_wr_t   gpr_wr;
   csrg_ptr_req_t  ptr_req;
   int             n_mismatch = 0;
   int             samples_checked = 0;
   csrg_row_t      rows [6] = '{'{1'b0, 5'h00, 16'h0011}, '{1'b0, 5'h1F, 16'h00EE},
      '{1'b1, 5'h02, 16'hBEEF}, '{1'b1, 5'h1A, 16'h0100}, '{1'b1, 5'h1C, 16'h2468},
      '{1'b1, 5'h1E, 16'h1000}};

   csrg_core i_csrg_core (.*);
   csrg_sram_model i_csrg_sram_model (.*);

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic io(logic w, logic [15:0] a, logic [7:0] d);
      @(posedge ref_clk);
      io_req <= '{w, !w, a, d};
      @(posedge ref_clk);
      io_req <= '0;
      #1;
   endtask

   task automatic ev(csrg_cpu_evt_t v, int n);
      @(posedge ref_clk);
      cpu_evt <= v;
      repeat (n) @(posedge ref_clk);
      cpu_evt <= '0;
      #1;
   endtask

   task automatic stk(csrg_stk_op_t op, logic [15:0] w);
      @(posedge ref_clk);
      stk_req <= '{op, w[7:0], w};
      @(posedge ref_clk);
      stk_req.op <= STK_NONE;
      #1;
   endtask

   task automatic wpop(logic [15:0] e);
      for (int i = 0; !pop_out.valid || stk_busy; i++) begin
         if (i == 8) begin
            n_mismatch++;
            tally_and_finish;
         end
         if (pop_out.valid)
            chk("pop", e, pop_out.data);
         @(posedge ref_clk);
         #1;
      end
      chk("pop", e, pop_out.data);
   endtask

   task automatic ptr(csrg_ptr_sel_t s, csrg_ptr_mode_t m, csrg_ptr_use_t u, logic [15:0] e);
      @(posedge ref_clk);
      ptr_req <= '{1'b1, s, m, u, 6'h05};
      @(posedge ref_clk);
      ptr_req <= '0;
      #1;
      chk("ptr_v", 16'h0001, 16'(ptr_addr.valid));
      chk("ptr", e, ptr_addr.data);
   endtask

   initial begin
      rst_n = 1'b0;
      io_req = '0;
      cpu_evt = '0;
      stk_req = '0;
      gpr_rd = '0;
      gpr_wr = '0;
      ptr_req = '0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      io(0, `CSRG_SPL_OFF, 8'h00);
      chk("spl", 16'h00FF, 16'(io_rdata));
      io(0, `CSRG_SPH_OFF, 8'h00);
      chk("sph", 16'h003F, 16'(io_rdata));
      foreach (rows[i]) begin
         @(posedge ref_clk);
         gpr_wr <= '{!rows[i].w, rows[i].a, rows[i].d[7:0], rows[i].w, rows[i].a, rows[i].d};
         gpr_rd <= '{rows[i].a, rows[i].a, rows[i].a};
         @(posedge ref_clk);
         gpr_wr <= '0;
         @(posedge ref_clk);
         #1;
         chk("gpr_a", 16'(rows[i].d[7:0]), 16'(gpr_rd_a));
         chk("gpr_b", 16'(rows[i].d[7:0]), 16'(gpr_rd_b));
         if (rows[i].w)
            chk("gpr_w", rows[i].d, gpr_rd_w);
      end
      ptr(SEL_FIRST, PTR_DISP, USE_DATA, 16'h0105);
      ptr(SEL_FIRST, PTR_POSTINC, USE_DATA, 16'h0100);
      ptr(SEL_FIRST, PTR_PLAIN, USE_DATA, 16'h0101);
      ptr(SEL_SECOND, PTR_PREDEC, USE_DATA, 16'h2467);
      for (int u = 1; u < 4; u++)
         ptr(SEL_FIRST, PTR_PLAIN, csrg_ptr_use_t'(u), 16'h1000);
      io(1, `CSRG_SPL_OFF, 8'h34);
      chk("irq_blk", 16'h0001, 16'(irq_block));
      io(1, `CSRG_SPH_OFF, 8'h21);
      chk("irq_blk", 16'h0000, 16'(irq_block));
      io(0, `CSRG_SPL_OFF, 8'h00);
      chk("spl", 16'h0034, 16'(io_rdata));
      io(1, `CSRG_TEMP_OFF, 8'h5A);
      io(0, `CSRG_TEMP_OFF, 8'h00);
      chk("temp", 16'h005A, 16'(io_rdata));
      io(0, `CSRG_SPH_OFF, 8'h00);
      chk("sph", 16'h005A, 16'(io_rdata));
      stk(STK_PUSH, 16'h00A5);
      chk("push_a", 16'h2134, stk_mem.addr);
      chk("push_d", 16'h00A5, 16'(stk_mem.wdata));
      stk(STK_POP, 16'h0000);
      chk("pop_a", 16'h2134, stk_mem.addr);
      wpop(16'h00A5);
      stk(STK_CALL, 16'h1234);
      chk("call_lo", 16'h2134, stk_mem.addr);
      chk("call_ld", 16'h0034, 16'(stk_mem.wdata));
      @(posedge ref_clk);
      #1;
      chk("call_hi", 16'h2133, stk_mem.addr);
      chk("call_hd", 16'h0012, 16'(stk_mem.wdata));
      chk("call_busy", 16'h0000, 16'(stk_busy));
      stk(STK_RET, 16'h0000);
      chk("ret_a", 16'h2133, stk_mem.addr);
      wpop(16'h1234);
      io(0, `CSRG_SPL_OFF, 8'h00);
      chk("spl", 16'h0034, 16'(io_rdata));
      io(1, `CSRG_CCP_OFF, `CSRG_KEY_IO);
      chk("irq_blk", 16'h0001, 16'(irq_block));
      io(0, `CSRG_CCP_OFF, 8'h00);
      chk("ccp", 16'h0001, 16'(io_rdata));
      ev(insn_ev, 3);
      chk("io_unl", 16'h0001, 16'(io_unlock));
      ev(insn_ev, 1);
      chk("io_unl", 16'h0000, 16'(io_unlock));
      io(1, `CSRG_CCP_OFF, `CSRG_KEY_SPM);
      io(0, `CSRG_CCP_OFF, 8'h00);
      chk("ccp", 16'h0002, 16'(io_rdata));
      for (int k = 0; k < 4; k++) begin
         io(1, `CSRG_CCP_OFF, `CSRG_KEY_IO);
         if (k == 3)
            io(1, `CSRG_TEMP_OFF, 8'h01);
         else
            ev(csrg_cpu_evt_t'(4'h8 >> k), 1);
         chk("close", 16'h0000, 16'(io_unlock));
      end
      io(1, `CSRG_CCP_OFF, 8'h55);
      io(0, `CSRG_CCP_OFF, 8'h00);
      chk("ccp", 16'h0000, 16'(io_rdata));
      tally_and_finish;
   end
endmodule
